// ### hw/simd_state_params.svh
// Constants for the SIMD architectural state block: save area rows, reset values, fields.
// Assumes the save area is addressed in 16-byte rows, row 0 at byte 0.
`ifndef SIMD_STATE_PARAMS_SVH
`define SIMD_STATE_PARAMS_SVH

// ****************************************************************************
// Save area rows (one row is 16 bytes).
// ****************************************************************************
`define ROW_X87_HDR     5'h00
`define ROW_CSR         5'h01
`define ROW_ST_BASE     5'h02
`define ROW_VEC_BASE    5'h0a
`define ROW_LAST_LEGACY 5'h11
`define ROW_LAST_LONG   5'h19

// ****************************************************************************
// Field positions within the rows and reset values.
// ****************************************************************************
`define CSR_IMG_LSB     64
`define FTW_LSB         32
`define FEATURE_BIT     26
`define DAZ_BIT         6
`define FTZ_BIT         15
`define CSR_RST         32'h00001f80
`define CSR_LEGAL_MASK  32'h0000ffff
`define FCW_RST         16'h037f
`define TAG_EMPTY       2'h3
`define TAG_VALID       2'h0
`define TAG_ZERO        2'h1
`define TAG_SPECIAL     2'h2

`endif

// ### hw/simd_state_pkg.sv
// Types shared by the SIMD state block: modes, operations, carriers.
// Assumes nothing beyond the constants header.
package simd_state_pkg;

	// Processor operating mode as seen by the block.
	typedef enum logic [2:0] {MODE_REAL, MODE_V86, MODE_PROT, MODE_COMPAT, MODE_LONG64} cpu_mode_t;

	// Whole-state operation requested by the pipeline.
	typedef enum logic {OP_SAVE, OP_RESTORE} op_t;

	// Sequencer states.
	typedef enum logic [1:0] {ST_IDLE, ST_SAVE, ST_CHECK, ST_LOAD} seq_state_t;

	// Register extension prefix as decoded.
	typedef struct packed {
		logic present;
		logic w;
		logic r;
	} rex_t;

	// Vector register write from the pipeline.
	typedef struct packed {
		logic         en;
		logic         scalar;
		logic [2:0]   sel;
		logic [127:0] data;
	} vec_wr_t;

	// Request towards the memory subsystem, one 16-byte row.
	typedef struct packed {
		logic         valid;
		logic         we;
		logic [4:0]   row;
		logic [127:0] data;
	} mem_req_t;

endpackage

// ### hw/simd_state_save_restore.sv
// SIMD architectural state: vector registers, control/status register, x87 aliases,
// and the whole-state save and restore sequencer.
// Assumes one clock, a memory port that accepts or returns one row per ready cycle.
`timescale 1ns/100ps
`include "simd_state_params.svh"

// Summary of operation
// [RL1] Save writes x87 and vector state
// [RL2] Restore checks control image, faults if illegal
// [RL3] Legal image: restore loads x87 and vectors
// [RL4] Feature bit 26 reports extension present
// [RL5] Vector registers are 128 bits wide
// [RL6] Scalar operations touch low quadword only
// [RL7] 32-bit control/status with DAZ and FTZ
// [RL8] Registers 8-15 only in 64-bit mode
// [RL9] Compatibility mode behaves as protected mode
// [RL10] Meaningless extension prefix silently ignored
// [RL11] Prefix width bit selects 64-bit GPRs
// [RL12] Vector registers never form memory addresses
// [RL13] Eight 64-bit packed integer registers
// [RL14] Usable in protected, real, v86 modes
// [RL15] No state beyond what save covers
// [RL16] Restore ignores the mask field
// [RL17] Upper vector rows untouched outside 64-bit mode
// [RL18] Save stores abridged tag in byte 4
// [RL19] Software supplies aligned area, keeps reserved bytes
module simd_state_save_restore
	import simd_state_pkg::*;
#(
	parameter int VEC_COUNT = 16,                 // Vector registers incl. 64-bit mode extras.
	parameter int PK_COUNT  = 8                   // Packed integer registers.
) (
	input  wire logic          clock_in,          // System clock.
	input  wire logic          rst_b_in,          // Asynchronous reset, active low.
	input  wire cpu_mode_t     mode_in,           // Current operating mode.
	input  wire rex_t          rex_in,            // Decoded extension prefix.
	input  wire logic          op_valid_in,       // Save or restore request.
	input  wire op_t           op_in,             // Which operation.
	output logic               op_ready_out,      // Sequencer idle, request taken.
	output logic               op_done_out,       // Pulse: operation finished.
	output logic               gp_fault_out,      // Pulse: illegal control image.
	output mem_req_t           mem_req_out,       // Row request to memory.
	input  wire logic          mem_ready_in,      // Memory accepts this row.
	input  wire logic [127:0]  mem_rdata_in,      // Read row, valid with ready.
	input  wire logic [2:0]    vec_rsel_in,       // Vector read select.
	output logic      [127:0]  vec_rd_out,        // Vector read data, one cycle later.
	output logic      [63:0]   vec_scalar_out,    // Low quadword of read data.
	input  wire vec_wr_t       vec_wr_in,         // Vector write.
	input  wire logic [2:0]    pk_sel_in,         // Packed integer select.
	input  wire logic          pk_we_in,          // Packed integer write.
	input  wire logic [63:0]   pk_wdata_in,       // Packed integer write data.
	output logic      [63:0]   pk_rd_out,         // Packed integer read data.
	input  wire logic          csr_we_in,         // Control/status write.
	input  wire logic [31:0]   csr_wdata_in,      // Control/status write data.
	output logic      [31:0]   csr_out,           // Control/status register.
	output logic               daz_out,           // Denormals-are-zeros control.
	output logic               ftz_out,           // Flush-to-zero control.
	output logic               gpr_wide_out,      // Use 64-bit general registers.
	output logic      [31:0]   feature_edx_out    // Feature query leaf 01H EDX.
);

	// ************************************************************************
	// Elaboration checks and storage.
	// ************************************************************************
	if (VEC_COUNT != 16 || PK_COUNT != 8) begin : g_bad_size
		$error("Save area layout serves only 16 vector and 8 packed registers.");
	end

	logic [127:0]   vec_r [VEC_COUNT];            // Vector registers, 128 bits each.
	logic [79:0]    st_r [PK_COUNT];              // x87 data registers, packed aliases.
	logic [1:0]     tag_r [PK_COUNT];             // x87 tags.
	logic [15:0]    fcw_r;                        // x87 control word.
	logic [15:0]    fsw_r;                        // x87 status word.
	logic [15:0]    fop_r;                        // x87 last opcode.
	logic [63:0]    fip_r;                        // x87 instruction pointer.
	logic [63:0]    fdp_r;                        // x87 data pointer.
	logic [31:0]    csr_r;                        // Control/status register.
	logic [7:0]     ftw_r;                        // Abridged tags held during restore.
	seq_state_t     state_r;                      // Sequencer state.
	logic [4:0]     row_r;                        // Current save area row.
	logic [127:0]   wdata_r;                      // Row image presented to memory.
	logic           is64_r;                       // Operation runs in 64-bit mode.
	logic           wide_r;                       // Width bit present on the operation.
	logic           done_r;                       // Done pulse.
	logic           fault_r;                      // Fault pulse.
	logic [127:0]   vec_rd_r;                     // Registered vector read.
	logic [63:0]    pk_rd_r;                      // Registered packed read.

	// ************************************************************************
	// Decode of mode, prefix and sequencer progress.
	// ************************************************************************
	// Only 64-bit mode differs; real, v86, protected, compatibility all match.
	wire        is64_w    = (mode_in == MODE_LONG64);                     // RL9 RL14
	// A prefix outside 64-bit mode is dropped without any fault.
	wire        rex_ok_w  = is64_w & rex_in.present;                      // RL10
	wire [3:0]  vsel_w    = {rex_ok_w & rex_in.r, vec_rsel_in};           // RL8
	wire [3:0]  wsel_w    = {rex_ok_w & rex_in.r, vec_wr_in.sel};         // RL8
	wire        idle_w    = (state_r == ST_IDLE);
	wire        accept_w  = !idle_w & mem_ready_in;
	wire [4:0]  last_w    = is64_r ? `ROW_LAST_LONG : `ROW_LAST_LEGACY;  // RL17
	wire        at_last_w = (row_r == last_w);
	wire [31:0] img_w     = mem_rdata_in[`CSR_IMG_LSB +: 32];
	wire        legal_w   = ((img_w & ~`CSR_LEGAL_MASK) == 32'h0);       // RL2
	wire        load_w    = (state_r == ST_LOAD) & mem_ready_in;
	wire        start_w   = idle_w & op_valid_in;
	// Width bit of the operation about to run, so row 0 is built with the new width.
	wire        wide_nxt  = start_w ? (rex_ok_w & rex_in.w) : wide_r;        // RL11
	wire [4:0]  row_nxt   = start_w ? ((op_in == OP_SAVE) ? `ROW_X87_HDR : `ROW_CSR) :
				(state_r == ST_CHECK && accept_w) ? `ROW_X87_HDR :
				accept_w ? 5'(row_r + 5'h1) : row_r;

	assign op_ready_out    = idle_w;
	assign gpr_wide_out    = rex_ok_w & rex_in.w;                         // RL11
	assign feature_edx_out = 32'h1 << `FEATURE_BIT;                       // RL4
	assign csr_out         = csr_r;                                       // RL7
	assign daz_out         = csr_r[`DAZ_BIT];
	assign ftz_out         = csr_r[`FTZ_BIT];
	assign op_done_out     = done_r;
	assign gp_fault_out    = fault_r;
	assign vec_rd_out      = vec_rd_r;
	assign vec_scalar_out  = vec_rd_r[63:0];                              // RL6
	assign pk_rd_out       = pk_rd_r;                                     // RL13
	// The row comes from the sequencer counter only, never from vector data.
	assign mem_req_out     = '{valid: !idle_w, we: (state_r == ST_SAVE),
				   row: row_r, data: wdata_r};                   // RL12

	// Tag derived from a loaded data register value.
	function automatic logic [1:0] tag_of(input logic [79:0] v);
		logic [14:0] e;
		e = v[78:64];
		if (e == 15'h0 && v[63:0] == 64'h0) return `TAG_ZERO;
		else if (e == 15'h0 || e == 15'h7fff) return `TAG_SPECIAL;
		else return `TAG_VALID;
	endfunction

	// Image of one save area row; every piece of state has a place here.
	function automatic logic [127:0] row_image(input logic [4:0] r);  // RL15
		logic [127:0] d;
		logic [7:0]   ab;
		d = 128'h0;
		for (int j = 0; j < 8; j++) ab[j] = (tag_r[j] != `TAG_EMPTY);   // RL18
		if (r == `ROW_X87_HDR) begin
			d[15:0]  = fcw_r;
			d[31:16] = fsw_r;
			d[`FTW_LSB +: 8] = ab;                                // RL18
			d[63:48] = fop_r;
			d[127:64] = wide_nxt ? fip_r : {32'h0, fip_r[31:0]};  // RL11
		end else if (r == `ROW_CSR) begin
			d[63:0]  = wide_nxt ? fdp_r : {32'h0, fdp_r[31:0]};
			d[95:64] = csr_r;
			d[127:96] = `CSR_LEGAL_MASK;
		end else if (r < `ROW_VEC_BASE) begin
			d[79:0] = st_r[3'(r - `ROW_ST_BASE)];
		end else if (r <= `ROW_LAST_LONG) begin
			d = vec_r[4'(r - `ROW_VEC_BASE)];
		end
		return d;
	endfunction

	// ************************************************************************
	// Sequencer: save walks rows out, restore checks then walks rows in.
	// ************************************************************************
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			state_r <= ST_IDLE;
			row_r   <= 5'h0;
			is64_r  <= 1'b0;
			wide_r  <= 1'b0;
			done_r  <= 1'b0;
			fault_r <= 1'b0;
		end else begin
			done_r  <= 1'b0;
			fault_r <= 1'b0;
			row_r   <= row_nxt;
			case (state_r)
			ST_IDLE: if (start_w) begin
				is64_r  <= is64_w;
				wide_r  <= rex_ok_w & rex_in.w;
				state_r <= (op_in == OP_SAVE) ? ST_SAVE : ST_CHECK;
			end
			ST_SAVE: if (mem_ready_in && at_last_w) begin            // RL1
				done_r  <= 1'b1;
				state_r <= ST_IDLE;
			end
			ST_CHECK: if (mem_ready_in) begin                        // RL2
				fault_r <= !legal_w;
				state_r <= legal_w ? ST_LOAD : ST_IDLE;
			end
			ST_LOAD: if (mem_ready_in && at_last_w) begin            // RL3
				done_r  <= 1'b1;
				state_r <= ST_IDLE;
			end
			default: state_r <= ST_IDLE;
			endcase
		end
	end

	// Row image follows the next row so it is ready when the row is presented.
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) wdata_r <= 128'h0;
		else wdata_r <= row_image(row_nxt);                               // RL1
	end

	// ************************************************************************
	// x87 header and control/status loads.
	// ************************************************************************
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			fcw_r <= `FCW_RST;
			fsw_r <= 16'h0;
			fop_r <= 16'h0;
			fip_r <= 64'h0;
			fdp_r <= 64'h0;
			ftw_r <= 8'h0;
			csr_r <= `CSR_RST;
		end else if (load_w && row_r == `ROW_X87_HDR) begin          // RL3
			fcw_r <= mem_rdata_in[15:0];
			fsw_r <= mem_rdata_in[31:16];
			ftw_r <= mem_rdata_in[`FTW_LSB +: 8];
			fop_r <= mem_rdata_in[63:48];
			fip_r <= wide_r ? mem_rdata_in[127:64] : {32'h0, mem_rdata_in[95:64]};
		end else if (load_w && row_r == `ROW_CSR) begin
			// The mask field in the upper word is deliberately not read.
			fdp_r <= wide_r ? mem_rdata_in[63:0] : {32'h0, mem_rdata_in[31:0]};  // RL16
			// Masked again: the row is read a second time after the check.
			csr_r <= img_w & `CSR_LEGAL_MASK;                      // RL3
		end else if (csr_we_in && idle_w) begin
			csr_r <= csr_wdata_in & `CSR_LEGAL_MASK;               // RL7
		end
	end

	// ************************************************************************
	// Per-entry storage: vector registers and x87/packed registers.
	// ************************************************************************
	for (genvar i = 0; i < VEC_COUNT; i++) begin : g_vec
		// Pipeline writes are dropped while a whole-state operation runs.
		wire wr_w = vec_wr_in.en & idle_w & (wsel_w == 4'(i));
		always_ff @(posedge clock_in or negedge rst_b_in) begin
			if (!rst_b_in) vec_r[i] <= 128'h0;
			else if (load_w && row_r == 5'(`ROW_VEC_BASE + i))
				vec_r[i] <= mem_rdata_in;                       // RL3 RL17
			else if (wr_w && vec_wr_in.scalar)
				vec_r[i][63:0] <= vec_wr_in.data[63:0];         // RL6
			else if (wr_w)
				vec_r[i] <= vec_wr_in.data;                     // RL5
		end
	end

	for (genvar j = 0; j < PK_COUNT; j++) begin : g_st
		wire ld_w = load_w & (row_r == 5'(`ROW_ST_BASE + j));
		always_ff @(posedge clock_in or negedge rst_b_in) begin
			if (!rst_b_in) begin
				st_r[j]  <= 80'h0;
				tag_r[j] <= `TAG_EMPTY;
			end else if (ld_w) begin
				st_r[j]  <= mem_rdata_in[79:0];
				tag_r[j] <= ftw_r[j] ? tag_of(mem_rdata_in[79:0]) : `TAG_EMPTY;
			end else if (pk_we_in && idle_w && pk_sel_in == 3'(j)) begin
				st_r[j]  <= {16'hffff, pk_wdata_in};            // RL13
				tag_r[j] <= `TAG_VALID;
			end
		end
	end

	// Read ports, registered.
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			vec_rd_r <= 128'h0;
			pk_rd_r  <= 64'h0;
		end else begin
			vec_rd_r <= vec_r[vsel_w];                              // RL8
			pk_rd_r  <= st_r[pk_sel_in][63:0];                      // RL13
		end
	end

	// ************************************************************************
	// Assertions and covers.
	// ************************************************************************
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!rst_b_in);

	illegal_faults_a: assert property ((state_r == ST_CHECK && mem_ready_in && !legal_w)
		|=> gp_fault_out && !op_done_out && state_r == ST_IDLE) // RL2
		else $error("Illegal control image did not fault.");
	legal_loads_a: assert property ((state_r == ST_CHECK && mem_ready_in && legal_w)
		|=> state_r == ST_LOAD && row_r == `ROW_X87_HDR && csr_r == $past(csr_r)) // RL3
		else $error("Legal image did not start loading.");
	save_ends_a: assert property ((state_r == ST_SAVE && mem_ready_in && at_last_w)
		|=> op_done_out && !mem_req_out.valid && op_ready_out) // RL1
		else $error("Save did not finish on its last row.");
	upper_rows_a: assert property ((mem_req_out.valid && !is64_r)
		|-> mem_req_out.row <= `ROW_LAST_LEGACY) // RL17
		else $error("Upper vector rows touched outside 64-bit mode.");
	csr_reserved_a: assert property ((csr_r & ~`CSR_LEGAL_MASK) == 32'h0) // RL7
		else $error("Control/status holds reserved bits.");
	scalar_write_a: assert property ((vec_wr_in.en && vec_wr_in.scalar && idle_w)
		|=> vec_r[$past(wsel_w)][127:64] == $past(vec_r[wsel_w][127:64])) // RL6
		else $error("Scalar write changed the high quadword.");
	prefix_ignored_a: assert property ((!is64_w) |-> !gpr_wide_out) // RL10
		else $error("Prefix honoured outside 64-bit mode.");
	abridged_tag_a: assert property ((mem_req_out.valid && mem_req_out.we
		&& mem_req_out.row == `ROW_X87_HDR)
		|-> mem_req_out.data[`FTW_LSB] == (tag_r[0] != `TAG_EMPTY)) // RL18
		else $error("Abridged tag bit wrong in saved header.");
	feature_bit_a: assert property (feature_edx_out[`FEATURE_BIT] == 1'b1) // RL4
		else $error("Feature bit not reported.");

	save_done_c: cover property (state_r == ST_SAVE ##[1:40] op_done_out);
	restore_fault_c: cover property (state_r == ST_CHECK ##1 gp_fault_out);
	restore_long_c: cover property (state_r == ST_LOAD && is64_r && row_r == `ROW_LAST_LONG);

endmodule // simd_state_save_restore

// ### tb/save_area_model.sv
// Behavioural memory holding the save area, one 16-byte row per entry.
// Assumes the block's row request port; the bench preloads and inspects mem_r.
`timescale 1ns/100ps
module save_area_model
	import simd_state_pkg::*;
(
	input  wire logic         clock_in,   // System clock.
	input  wire mem_req_t     req_in,     // Row request from the block.
	input  wire logic         slow_in,    // Accept only every other cycle.
	output logic              ready_out,  // Row taken at this edge.
	output logic      [127:0] rdata_out   // Read row, valid with ready.
);
	// ********************************************************************
	// Storage and acceptance.
	// ********************************************************************
	logic [127:0] mem_r [0:31];      // Save area rows; unwritten rows keep their bytes.
	logic [127:0] last_r  = '0;      // Last row handed out.
	logic         phase_r = 1'b0;    // Stall phase when slow.
	// Accept at once, or every other cycle when slow, to stretch the sequence.
	assign ready_out = req_in.valid & (~slow_in | phase_r);
	// An idle data bus shows the inverse of the last row, so no stale value passes.
	assign rdata_out = ready_out ? mem_r[req_in.row] : ~last_r;
	// Writes land at the accepting edge; only the addressed row changes.
	always @(posedge clock_in) begin
		phase_r <= ~phase_r;
		if (ready_out && req_in.we) begin
			mem_r[req_in.row] <= req_in.data;
		end
		if (ready_out) begin
			last_r <= rdata_out;
		end
	end
endmodule // save_area_model

// ### tb/simd_state_save_restore_test.sv
// Self-checking bench for the SIMD state block and its save/restore sequencer.
// Assumes the save area model beside it; inputs change at the falling edge.
`timescale 1ns/100ps
module simd_state_save_restore_test
	import simd_state_pkg::*;
;
	// ********************************************************************
	// Signals.
	// ********************************************************************
	logic          clock_in, rst_b_in, op_valid_in, op_ready_out, op_done_out, gp_fault_out;
	cpu_mode_t     mode_in;
	rex_t          rex_in;
	op_t           op_in;
	mem_req_t      mem_req_out;
	logic          mem_ready_in, pk_we_in, csr_we_in, daz_out, ftz_out, gpr_wide_out, slow;
	logic [127:0]  mem_rdata_in, vec_rd_out;
	logic [63:0]   vec_scalar_out, pk_wdata_in, pk_rd_out;
	logic [2:0]    vec_rsel_in, pk_sel_in;
	vec_wr_t       vec_wr_in;
	logic [31:0]   csr_wdata_in, csr_out, feature_edx_out;
	logic [127:0]  exp_v [0:15];    // Expected vector contents.
	int            err_total = 0, n_tests = 0, i;
	// One row of the ordinary cases: mode, prefix, written value and expected outputs.
	typedef struct packed {
		cpu_mode_t mode; rex_t register_extension_prefix; logic [31:0] wr, csr; logic daz, ftz, wide;
	} row_t;
	row_t rows [0:5] = '{
		'{MODE_REAL,   3'b111, 32'h00000040, 32'h00000040, 1'b1, 1'b0, 1'b0},
		'{MODE_V86,    3'b110, 32'h00008000, 32'h00008000, 1'b0, 1'b1, 1'b0},
		'{MODE_PROT,   3'b110, 32'hffff1f80, 32'h00001f80, 1'b0, 1'b0, 1'b0},
		'{MODE_COMPAT, 3'b110, 32'h0000ffff, 32'h0000ffff, 1'b1, 1'b1, 1'b0},
		'{MODE_LONG64, 3'b110, 32'h00000000, 32'h00000000, 1'b0, 1'b0, 1'b1},
		'{MODE_LONG64, 3'b010, 32'h00001f80, 32'h00001f80, 1'b0, 1'b0, 1'b0}};
	// ********************************************************************
	// Design, far side and clock.
	// ********************************************************************
	simd_state_save_restore uut (.clock_in(clock_in), .rst_b_in(rst_b_in), .mode_in(mode_in),
		.rex_in(rex_in), .op_valid_in(op_valid_in), .op_in(op_in), .op_ready_out(op_ready_out),
		.op_done_out(op_done_out), .gp_fault_out(gp_fault_out), .mem_req_out(mem_req_out),
		.mem_ready_in(mem_ready_in), .mem_rdata_in(mem_rdata_in), .vec_rsel_in(vec_rsel_in),
		.vec_rd_out(vec_rd_out), .vec_scalar_out(vec_scalar_out), .vec_wr_in(vec_wr_in),
		.pk_sel_in(pk_sel_in), .pk_we_in(pk_we_in), .pk_wdata_in(pk_wdata_in),
		.pk_rd_out(pk_rd_out), .csr_we_in(csr_we_in), .csr_wdata_in(csr_wdata_in),
		.csr_out(csr_out), .daz_out(daz_out), .ftz_out(ftz_out), .gpr_wide_out(gpr_wide_out),
		.feature_edx_out(feature_edx_out));
	save_area_model area (.clock_in(clock_in), .req_in(mem_req_out), .slow_in(slow),
		.ready_out(mem_ready_in), .rdata_out(mem_rdata_in));
	// Free-running 50 MHz clock.
	initial begin
		clock_in = 1'b0;
		forever #10 clock_in = ~clock_in;
	end
	// ********************************************************************
	// Tasks; each starts and ends just after a falling edge.
	// ********************************************************************
	// Compare and count; a difference is reported at once.
	task automatic chk(input string nm, input logic [127:0] exp, input logic [127:0] got);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// Distinct fill pattern for each vector register.
	function automatic logic [127:0] vpat(input int k);
		return {16{8'(8'h11 * (k + 1))}};
	endfunction
	// One vector write cycle.
	task automatic wr_vec(input logic [2:0] s, input logic sc, input logic [127:0] d);
		vec_wr_in = '{1'b1, sc, s, d};
		@(negedge clock_in);
		vec_wr_in.en = 1'b0;
		@(negedge clock_in);
	endtask
	// Select a vector; the registered read is settled one edge later.
	task automatic rd_vec(input logic [2:0] s);
		vec_rsel_in = s;
		@(negedge clock_in);
	endtask
	// Issue one operation, optionally try a refused write while busy, await its end.
	task automatic run_op(input op_t op, input logic fault, input logic poke);
		int k;
		op_valid_in = 1'b1;
		op_in = op;
		@(negedge clock_in);
		op_valid_in = 1'b0;
		csr_we_in = poke;
		csr_wdata_in = 32'h00007f80;
		@(negedge clock_in);
		csr_we_in = 1'b0;
		for (k = 0; k < 200 && op_done_out !== 1'b1 && gp_fault_out !== 1'b1; k++)
			@(negedge clock_in);
		chk("gp_fault_out", fault, gp_fault_out);
		chk("op_done_out", !fault, op_done_out);
	endtask
	// Single place where the run ends.
	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// Watchdog well beyond the few hundred cycles the tests need.
	initial begin
		#400000;
		err_total++;
		give_verdict();
	end
	// ********************************************************************
	// Main sequence.
	// ********************************************************************
	initial begin
		rst_b_in = 1'b0; mode_in = MODE_PROT; rex_in = '0; op_valid_in = 1'b0; op_in = OP_SAVE;
		vec_rsel_in = '0; vec_wr_in = '0; pk_sel_in = '0; pk_we_in = 1'b0; pk_wdata_in = '0;
		csr_we_in = 1'b0; csr_wdata_in = '0; slow = 1'b0;
		for (i = 0; i < 32; i++) area.mem_r[i] = {8{16'h5a5a}};
		repeat (8) @(negedge clock_in);
		rst_b_in = 1'b1;
		chk("csr_out reset", 32'h00001f80, csr_out);
		chk("op_ready_out reset", 1'b1, op_ready_out);
		chk("feature bit", 1'b1, feature_edx_out[26]);
		// Control/status writes across every mode and three prefix forms.
		csr_we_in = 1'b1;
		for (i = 0; i < 6; i++) begin
			mode_in = rows[i].mode; rex_in = rows[i].register_extension_prefix;
			csr_wdata_in = rows[i].wr;
			@(negedge clock_in);
			chk("csr_out", rows[i].csr, csr_out);
			chk("daz_out", rows[i].daz, daz_out);
			chk("ftz_out", rows[i].ftz, ftz_out);
			chk("gpr_wide_out", rows[i].wide, gpr_wide_out);
		end
		csr_we_in = 1'b0;
		// Lower vectors in protected mode, then a scalar write into one.
		mode_in = MODE_PROT; rex_in = 3'b101;
		for (i = 0; i < 8; i++) begin exp_v[i] = vpat(i); wr_vec(i, 1'b0, vpat(i)); end
		wr_vec(3'h3, 1'b1, {64'hffffffffffffffff, 64'h0123456789abcdef});
		exp_v[3][63:0] = 64'h0123456789abcdef;
		rd_vec(3'h3);
		chk("vec3 after scalar", exp_v[3], vec_rd_out);
		chk("vec_scalar_out", exp_v[3][63:0], vec_scalar_out);
		// Upper vectors reachable only through the prefix in 64-bit mode.
		mode_in = MODE_LONG64;
		for (i = 8; i < 16; i++) begin exp_v[i] = vpat(i); wr_vec(i - 8, 1'b0, vpat(i)); end
		rex_in = 3'b100;
		rd_vec(3'h3);
		chk("vec3 in 64-bit", exp_v[3], vec_rd_out);
		mode_in = MODE_COMPAT; rex_in = 3'b101;
		exp_v[2] = {4{32'h2468ace0}};
		wr_vec(3'h2, 1'b0, exp_v[2]);
		rd_vec(3'h2);
		chk("vec2 compat", exp_v[2], vec_rd_out);
		mode_in = MODE_LONG64;
		rd_vec(3'h2);
		chk("vec10", exp_v[10], vec_rd_out);
		// Packed integer alias of an x87 register.
		pk_sel_in = 3'h2; pk_we_in = 1'b1; pk_wdata_in = 64'hfedcba9876543210;
		@(negedge clock_in);
		pk_we_in = 1'b0;
		@(negedge clock_in);
		chk("pk_rd_out", 64'hfedcba9876543210, pk_rd_out);
		// Save outside 64-bit mode, with a refused write while busy.
		mode_in = MODE_PROT; rex_in = '0;
		run_op(OP_SAVE, 1'b0, 1'b1);
		chk("csr after busy write", 32'h00001f80, csr_out);
		chk("tag byte", 8'h04, area.mem_r[1'b0][39:32]);
		chk("csr image", 32'h00001f80, area.mem_r[1][95:64]);
		chk("mask field", 32'h0000ffff, area.mem_r[1][127:96]);
		chk("x87 row 2", {16'hffff, 64'hfedcba9876543210}, area.mem_r[4][79:0]);
		for (i = 0; i < 8; i++) chk("vec row", exp_v[i], area.mem_r[10 + i]);
		for (i = 18; i < 26; i++) chk("upper row kept", {8{16'h5a5a}}, area.mem_r[i]);
		// Save in 64-bit mode against a stalling memory.
		mode_in = MODE_LONG64; slow = 1'b1;
		run_op(OP_SAVE, 1'b0, 1'b0);
		slow = 1'b0;
		for (i = 8; i < 16; i++) chk("upper vec row", exp_v[i], area.mem_r[10 + i]);
		// Restore of an illegal control image faults and loads nothing.
		mode_in = MODE_PROT;
		area.mem_r[10] = {4{32'h77777777}};
		area.mem_r[18] = {4{32'h66666666}};
		area.mem_r[1][95:64] = 32'h00010000;
		run_op(OP_RESTORE, 1'b1, 1'b0);
		chk("csr after fault", 32'h00001f80, csr_out);
		rd_vec(3'h0);
		chk("vec0 after fault", exp_v[0], vec_rd_out);
		// Legal restore ignores the mask field and leaves upper vectors alone.
		area.mem_r[1][127:64] = {32'hdeadbeef, 32'h00000040};
		run_op(OP_RESTORE, 1'b0, 1'b0);
		chk("csr restored", 32'h00000040, csr_out);
		rd_vec(3'h0);
		chk("vec0 restored", {4{32'h77777777}}, vec_rd_out);
		mode_in = MODE_LONG64; rex_in = 3'b101;
		rd_vec(3'h0);
		chk("vec8 kept", exp_v[8], vec_rd_out);
		// Wide 64-bit restore loads upper rows and the full pointer; a narrow save cuts it.
		area.mem_r[0][127:64] = 64'h89abcdef01234567;
		rex_in = 3'b110;
		run_op(OP_RESTORE, 1'b0, 1'b0);
		rex_in = 3'b101;
		rd_vec(3'h0);
		chk("vec8 restored", {4{32'h66666666}}, vec_rd_out);
		rex_in = 3'b100;
		run_op(OP_SAVE, 1'b0, 1'b0);
		chk("narrow fip", {32'h0, 32'h01234567}, area.mem_r[0][127:64]);
		give_verdict();
	end
endmodule // simd_state_save_restore_test
